/* File: dcr_pkg.sv */
package dcr_pkg;

  localparam logic [3:0] ADDR_PWR0   = 4'h0;
  localparam logic [3:0] ADDR_PWR1   = 4'h1;
  localparam logic [3:0] ADDR_MIX0   = 4'h2;
  localparam logic [3:0] ADDR_MIX1   = 4'h3;
  localparam logic [3:0] ADDR_OSC0   = 4'h4;
  localparam logic [3:0] ADDR_OSC1   = 4'h5;
  localparam logic [3:0] ADDR_SDIV0  = 4'h6;
  localparam logic [3:0] ADDR_SDIV1  = 4'h7;
  localparam logic [3:0] ADDR_GLOBAL = 4'h8;
  localparam logic [3:0] ADDR_TEST   = 4'h9;
  localparam logic [3:0] ADDR_SYNC   = 4'hF;

  // Power/loop register bit positions
  localparam int PWR_RSVD_BIT  = 6;
  localparam int PWR_RLOOP_BIT = 5;
  localparam int PWR_DIGITAL_FILTER_LOOP_BIT = 4;
  localparam int PWR_PDN_BIT   = 3;
  localparam int PWR_CLR_BIT   = 2;
  localparam int PWR_TRANSMIT_OUTPUT_ENABLE_BIT  = 1;
  localparam int PWR_LLOOP_BIT = 0;
  localparam logic [7:0] PWR_RESET = 8'h0C;

  // Gain/mixer register field positions
  localparam int MIX_HPF_BIT  = 6;
  localparam int MIX_GAIN_LSB = 4;
  localparam int MIX_RX_LSB   = 2;
  localparam int MIX_TX_LSB   = 0;
  localparam logic [7:0] MIX_RESET = 8'h00;

  // Oversampling clock register
  localparam int OSC_SEL_BIT = 6;
  localparam logic [5:0] HIGH_SPEED_DIVIDER_RESET = 6'h10;
  localparam logic       SEL_RESET   = 1'b0;

  localparam logic [6:0] SAMPLING_DIVIDER_RESET = 7'h33;
  localparam logic [6:0] SAMPLING_DIVIDER_MIN   = 7'h33;

  localparam logic [7:0] REG_ZERO = 8'h00;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dcr_req_type;

  typedef struct packed {
    logic       remoteLoop;
    logic       digitalLoop;
    logic       codecClear;
    logic       powerDown;
    logic       txEnable;
    logic       localLoop;
    logic       highpassEn;
    logic [1:0] inputGain;
    logic [1:0] mixRxLevel;
    logic [1:0] mixTxLevel;
    logic [5:0] highSpeedDiv;
    logic       extClockSel;
    logic [6:0] samplingDiv;
  } dcr_codec_type;

endpackage

/* File: dcr_control_regs.sv */
`timescale 1ns/1ps
// Contract
// - Decode 4-bit address; codec pairs 0x0-0x7, global 0x8, test 0x9, sync 0xF. Code stores nothing at 0x8-0xF; writes there are ignored and reads give zero.
// - Remote-loop bit routes receive modulator bit to D/A input; resets 0.
// - Digital-loop bit feeds interpolator output into decimator; resets 0.
// - Clear bit forces zero into all digital stages; resets 1.
// - Power-down bit stops processing and powers down analog; resets 1.
// - Transmit-enable turns on differential output; zero output while 0.
// - Local analog loop feeds output pins back to input amplifier.
// - Codec 1 copies power, mixer, oversample registers at 0x1, 0x3, 0x5.
// - High-pass enable adds voice D/A high-pass below 0.005 of rate.
// - Two-bit input gain: 0, 12, 24, 36 dB; resets 0.
// - Mixer sums four sources, each scaled by own level field.
// - Level codes: off; rx 1.5/tx 0.5; rx 3/tx 1; rx 6/tx 2.
// - Several mixer sources may be active simultaneously.
// - All four level fields zero powers down speaker driver and mixer.
// - Codec output amplifier unaffected by mixer settings or speaker off.
// - Six-bit high-speed divider sets oversampling divide; resets 0x10.
// - Write-only clock select: crystal when 0, external clock when 1.
// - Sampling divider resets 0x33; writes below 0x33 store 0x33.
// - Most significant bit of every register always reads zero.
// - On external clock only sampling divider applies.
// - All registers reachable through either serial port.
module dcr_control_regs #(
  parameter int NUM_PORTS = 2
) (
  input  wire logic                  mclk,         // System clock
  input  wire logic                  sys_rst,      // Sync reset, high
  input  wire logic                  softReset,    // Software reset pulse
  input  dcr_pkg::dcr_req_type       portReq [NUM_PORTS], // Per-port access
  output logic [7:0]                 portRdata [NUM_PORTS], // Read data
  output logic [NUM_PORTS-1:0]       portRvalid,   // Read data valid
  output dcr_pkg::dcr_codec_type     codecCfg [2], // Per-codec controls
  output logic [1:0]                 osrDivide [2] [0:0], // Unused shape
  output logic [1:0]                 dacBitFromMod, // Remote loop route
  output logic [1:0]                 decimFromInterp, // Digital loop route
  output logic [1:0]                 stagesCleared, // Digital stages held 0
  output logic [1:0]                 codecRunning,  // Processing enabled
  output logic [1:0]                 analogPowered, // Analog circuitry on
  output logic [1:0]                 txStageOn,     // Differential stage on
  output logic [1:0]                 ampLoopback,   // Analog local loop
  output logic [1:0]                 voiceHighpass, // Extra D/A high-pass
  output logic [5:0]                 inGainDb [2],  // Input gain in dB
  output logic [3:0]                 mixWeight [4], // Gain x2: Rx0,Tx0,Rx1,Tx1
  output logic [3:0]                 mixActive,     // Per-source connect
  output logic                       speakerPowered, // Speaker driver on
  output logic [1:0]                 osrClockExt,   // Clock from ext master
  output logic [5:0]                 osrDivEff [2], // Divider in effect
  output logic [6:0]                 sampleDiv [2]  // Sampling divider
);

  dcr_pkg::dcr_codec_type cfg_r [2];
  dcr_pkg::dcr_codec_type cfg_nxt [2];
  logic [7:0] rdata_r [NUM_PORTS];
  logic [7:0] rdata_nxt [NUM_PORTS];
  logic [NUM_PORTS-1:0] rvalid_r;
  logic [NUM_PORTS-1:0] rvalid_nxt;

  // Readback of one address; write-only and reserved bits give zero
  function automatic logic [7:0] readReg(
    input logic [3:0] addr,
    input dcr_pkg::dcr_codec_type c0,
    input dcr_pkg::dcr_codec_type c1
  );
    dcr_pkg::dcr_codec_type c;
    logic [7:0] v;
    c = addr[0] ? c1 : c0;
    v = dcr_pkg::REG_ZERO;
    if (addr == dcr_pkg::ADDR_PWR0 || addr == dcr_pkg::ADDR_PWR1) begin
      v[dcr_pkg::PWR_RLOOP_BIT] = c.remoteLoop;
      v[dcr_pkg::PWR_DIGITAL_FILTER_LOOP_BIT] = c.digitalLoop;
      v[dcr_pkg::PWR_PDN_BIT]   = c.powerDown;
      v[dcr_pkg::PWR_CLR_BIT]   = c.codecClear;
      v[dcr_pkg::PWR_TRANSMIT_OUTPUT_ENABLE_BIT]  = c.txEnable;
      v[dcr_pkg::PWR_LLOOP_BIT] = c.localLoop;
    end else if (addr == dcr_pkg::ADDR_MIX0 || addr == dcr_pkg::ADDR_MIX1) begin
      v[dcr_pkg::MIX_HPF_BIT] = c.highpassEn;
      v[dcr_pkg::MIX_GAIN_LSB +: 2] = c.inputGain;
      v[dcr_pkg::MIX_RX_LSB +: 2] = c.mixRxLevel;
      v[dcr_pkg::MIX_TX_LSB +: 2] = c.mixTxLevel;
    end else if (addr == dcr_pkg::ADDR_OSC0 || addr == dcr_pkg::ADDR_OSC1) begin
      v[5:0] = c.highSpeedDiv;
    end else if (addr == dcr_pkg::ADDR_SDIV0 ||
                 addr == dcr_pkg::ADDR_SDIV1) begin
      v[6:0] = c.samplingDiv;
    end
    // Global, test, sync and unmapped addresses read zero here
    v[7] = 1'b0;
    return v;
  endfunction

  always_comb begin
    cfg_nxt = cfg_r;
    // Port order sets priority: higher index wins on same-cycle writes
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (portReq[p].valid && portReq[p].write &&
          portReq[p].addr[3] == 1'b0) begin
        case (portReq[p].addr[2:1])
          2'b00: begin
            // Reserved bit is not stored, whatever the host sends
            cfg_nxt[portReq[p].addr[0]].remoteLoop  =
              portReq[p].wdata[dcr_pkg::PWR_RLOOP_BIT];
            cfg_nxt[portReq[p].addr[0]].digitalLoop =
              portReq[p].wdata[dcr_pkg::PWR_DIGITAL_FILTER_LOOP_BIT];
            cfg_nxt[portReq[p].addr[0]].powerDown   =
              portReq[p].wdata[dcr_pkg::PWR_PDN_BIT];
            cfg_nxt[portReq[p].addr[0]].codecClear  =
              portReq[p].wdata[dcr_pkg::PWR_CLR_BIT];
            cfg_nxt[portReq[p].addr[0]].txEnable    =
              portReq[p].wdata[dcr_pkg::PWR_TRANSMIT_OUTPUT_ENABLE_BIT];
            cfg_nxt[portReq[p].addr[0]].localLoop   =
              portReq[p].wdata[dcr_pkg::PWR_LLOOP_BIT];
          end
          2'b01: begin
            cfg_nxt[portReq[p].addr[0]].highpassEn =
              portReq[p].wdata[dcr_pkg::MIX_HPF_BIT];
            cfg_nxt[portReq[p].addr[0]].inputGain =
              portReq[p].wdata[dcr_pkg::MIX_GAIN_LSB +: 2];
            cfg_nxt[portReq[p].addr[0]].mixRxLevel =
              portReq[p].wdata[dcr_pkg::MIX_RX_LSB +: 2];
            cfg_nxt[portReq[p].addr[0]].mixTxLevel =
              portReq[p].wdata[dcr_pkg::MIX_TX_LSB +: 2];
          end
          2'b10: begin
            cfg_nxt[portReq[p].addr[0]].extClockSel =
              portReq[p].wdata[dcr_pkg::OSC_SEL_BIT];
            cfg_nxt[portReq[p].addr[0]].highSpeedDiv =
              portReq[p].wdata[5:0];
          end
          default: begin
            if (portReq[p].wdata[6:0] < dcr_pkg::SAMPLING_DIVIDER_MIN) begin
              cfg_nxt[portReq[p].addr[0]].samplingDiv =
                dcr_pkg::SAMPLING_DIVIDER_MIN;
            end else begin
              cfg_nxt[portReq[p].addr[0]].samplingDiv =
                portReq[p].wdata[6:0];
            end
          end
        endcase
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      rvalid_nxt[p] = portReq[p].valid && !portReq[p].write;
      rdata_nxt[p]  = readReg(portReq[p].addr, cfg_r[0], cfg_r[1]);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || softReset) begin
      for (int c = 0; c < 2; c++) begin
        cfg_r[c].remoteLoop   <= dcr_pkg::PWR_RESET[dcr_pkg::PWR_RLOOP_BIT];
        cfg_r[c].digitalLoop  <= dcr_pkg::PWR_RESET[dcr_pkg::PWR_DIGITAL_FILTER_LOOP_BIT];
        cfg_r[c].codecClear   <= dcr_pkg::PWR_RESET[dcr_pkg::PWR_CLR_BIT];
        cfg_r[c].powerDown    <= dcr_pkg::PWR_RESET[dcr_pkg::PWR_PDN_BIT];
        cfg_r[c].txEnable     <= dcr_pkg::PWR_RESET[dcr_pkg::PWR_TRANSMIT_OUTPUT_ENABLE_BIT];
        cfg_r[c].localLoop    <= dcr_pkg::PWR_RESET[dcr_pkg::PWR_LLOOP_BIT];
        cfg_r[c].highpassEn   <= dcr_pkg::MIX_RESET[dcr_pkg::MIX_HPF_BIT];
        cfg_r[c].inputGain    <= dcr_pkg::MIX_RESET[dcr_pkg::MIX_GAIN_LSB +: 2];
        cfg_r[c].mixRxLevel   <= dcr_pkg::MIX_RESET[dcr_pkg::MIX_RX_LSB +: 2];
        cfg_r[c].mixTxLevel   <= dcr_pkg::MIX_RESET[dcr_pkg::MIX_TX_LSB +: 2];
        cfg_r[c].highSpeedDiv <= dcr_pkg::HIGH_SPEED_DIVIDER_RESET;
        cfg_r[c].extClockSel  <= dcr_pkg::SEL_RESET;
        cfg_r[c].samplingDiv  <= dcr_pkg::SAMPLING_DIVIDER_RESET;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        rdata_r[p] <= dcr_pkg::REG_ZERO;
      end
      rvalid_r <= '0;
    end else begin
      cfg_r    <= cfg_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign portRdata  = rdata_r;
  assign portRvalid = rvalid_r;
  assign codecCfg   = cfg_r;
  assign osrDivide[0][0] = 2'b00;
  assign osrDivide[1][0] = 2'b00;

  // Mixer gains are carried doubled so the half steps stay integral
  function automatic logic [3:0] mixGain(input logic [1:0] lvl,
                                         input logic isRx);
    logic [3:0] g;
    g = 4'h0;
    case (lvl)
      2'b01:   g = isRx ? 4'h3 : 4'h1;
      2'b10:   g = isRx ? 4'h6 : 4'h2;
      2'b11:   g = isRx ? 4'hC : 4'h4;
      default: g = 4'h0;
    endcase
    return g;
  endfunction

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_codec
      assign dacBitFromMod[c]   = cfg_r[c].remoteLoop;
      assign decimFromInterp[c] = cfg_r[c].digitalLoop;
      assign stagesCleared[c]   = cfg_r[c].codecClear;
      assign codecRunning[c]    = ~cfg_r[c].powerDown;
      assign analogPowered[c]   = ~cfg_r[c].powerDown;
      // Stage holds zero differential unless enabled and powered
      assign txStageOn[c]   = cfg_r[c].txEnable & ~cfg_r[c].powerDown;
      assign ampLoopback[c] = cfg_r[c].localLoop;
      assign voiceHighpass[c] = cfg_r[c].highpassEn;
      assign inGainDb[c] = 6'(12 * cfg_r[c].inputGain);
      assign mixWeight[2*c]   = mixGain(cfg_r[c].mixRxLevel, 1'b1);
      assign mixWeight[2*c+1] = mixGain(cfg_r[c].mixTxLevel, 1'b0);
      assign mixActive[2*c]   = |cfg_r[c].mixRxLevel;
      assign mixActive[2*c+1] = |cfg_r[c].mixTxLevel;
      assign osrClockExt[c] = cfg_r[c].extClockSel;
      // External master clock already is the oversampling clock
      assign osrDivEff[c] = cfg_r[c].extClockSel ? 6'h01
                                                 : cfg_r[c].highSpeedDiv;
      assign sampleDiv[c] = cfg_r[c].samplingDiv;
    end
  endgenerate

  // Codec output path does not depend on the mixer at all
  assign speakerPowered = |mixActive;

endmodule

/* File: dcr_properties.sv */
`timescale 1ns/1ps
module dcr_properties #(
  parameter int NUM_PORTS = 2
) (
  input wire logic                 mclk,           // Clock
  input wire logic                 sys_rst,        // Reset
  input wire logic                 softReset,      // Soft reset
  input dcr_pkg::dcr_req_type      portReq [NUM_PORTS], // Requests
  input wire logic [7:0]           portRdata [NUM_PORTS], // Read data
  input wire logic [NUM_PORTS-1:0] portRvalid,     // Read valid
  input dcr_pkg::dcr_codec_type    codecCfg [2],   // Stored fields
  input wire logic [1:0]           stagesCleared,  // Clear level
  input wire logic [1:0]           codecRunning,   // Run level
  input wire logic [1:0]           txStageOn,      // Output stage
  input wire logic [3:0]           mixActive,      // Mixer sources
  input wire logic                 speakerPowered, // Speaker on
  input wire logic [1:0]           osrClockExt,    // External clock
  input wire logic [5:0]           osrDivEff [2],  // Divider used
  input wire logic [6:0]           sampleDiv [2]   // Sampling divider
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst || softReset);
  a_read_answer:
    assert property (portReq[0].valid && !portReq[0].write |=> portRvalid[0])
      else $error("read got no answer");
  a_unmapped_zero:
    assert property (portReq[1].valid && !portReq[1].write && portReq[1].addr[3]
      |=> portRdata[1] == 8'h00) else $error("upper address read nonzero");
  a_msb_zero:
    assert property (portRvalid[0] |-> !portRdata[0][7])
      else $error("read data top bit set");
  a_sdiv_floor:
    assert property (sampleDiv[0] >= 7'h33 && sampleDiv[1] >= 7'h33)
      else $error("sampling divider below floor");
  a_sdiv_store:
    assert property (portReq[0].valid && portReq[0].write && !portReq[1].valid
      && portReq[0].addr == 4'h6 && portReq[0].wdata[6:0] >= 7'h33
      |=> sampleDiv[0] == $past(portReq[0].wdata[6:0]))
      else $error("sampling divider write lost");
  a_ext_divider:
    assert property (osrClockExt[0] |-> osrDivEff[0] == 6'h01)
      else $error("divider applied on external clock");
  a_xtal_divider:
    assert property (!osrClockExt[1] |-> osrDivEff[1] == codecCfg[1].highSpeedDiv)
      else $error("crystal divider not applied");
  a_ctrl_levels:
    assert property (stagesCleared == {codecCfg[1].codecClear,
      codecCfg[0].codecClear} && codecRunning == ~{codecCfg[1].powerDown,
      codecCfg[0].powerDown} && txStageOn == ({codecCfg[1].txEnable,
      codecCfg[0].txEnable} & ~{codecCfg[1].powerDown,
      codecCfg[0].powerDown})) else $error("control level mismatch");
  a_speaker_any:
    assert property (speakerPowered == (mixActive != 4'h0))
      else $error("speaker power wrong");
  a_reset_state:
    assert property (disable iff (1'b0) sys_rst |=> codecCfg[0].powerDown
      && codecCfg[0].codecClear && !codecCfg[0].txEnable)
      else $error("reset state wrong");
endmodule
bind dcr_control_regs dcr_properties #(.NUM_PORTS(NUM_PORTS)) props_i (
  .mclk(mclk), .sys_rst(sys_rst), .softReset(softReset),
  .portReq(portReq), .portRdata(portRdata), .portRvalid(portRvalid),
  .codecCfg(codecCfg), .stagesCleared(stagesCleared),
  .codecRunning(codecRunning), .txStageOn(txStageOn),
  .mixActive(mixActive), .speakerPowered(speakerPowered),
  .osrClockExt(osrClockExt), .osrDivEff(osrDivEff), .sampleDiv(sampleDiv));

/* File: dcr_host.sv */
`timescale 1ns/1ps
module dcr_host (
  input  wire logic           mclk, // System clock
  output dcr_pkg::dcr_req_type req   // Request into the bank
);
  initial req = '0;
  // Lines flip on release so a stale word never looks live
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a <= dcr_pkg::ADDR_PWR1) v[dcr_pkg::PWR_RSVD_BIT] = 1'b0;
    @(posedge mclk);
    req <= '{1'b1, w, a, v};
    @(posedge mclk);
    req <= '{1'b0, ~w, ~a, ~v};
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic                   mclk, sys_rst, softReset;
  dcr_pkg::dcr_req_type   portReq [2];
  logic [7:0]             portRdata [2];
  dcr_pkg::dcr_codec_type codecCfg [2];
  logic [1:0]             portRvalid, stagesCleared, codecRunning;
  logic [1:0]             txStageOn, osrClockExt;
  logic [1:0]             dacBitFromMod, decimFromInterp, analogPowered;
  logic [1:0]             ampLoopback, voiceHighpass;
  logic [5:0]             inGainDb [2], osrDivEff [2];
  logic [3:0]             mixWeight [4], mixActive;
  logic                   speakerPowered;
  logic [6:0]             sampleDiv [2];
  logic [7:0]             expQ [2][$];
  logic [7:0]             d0, d1;
  int                     failures = 0, n_checks = 0;
  localparam logic [7:0] RST_MAP [8] = '{8'h0C, 8'h0C, 8'h00, 8'h00,
    8'h10, 8'h10, 8'h33, 8'h33};
  localparam logic [7:0] RXW [4] = '{8'h00, 8'h03, 8'h06, 8'h0C};
  localparam logic [7:0] TXW [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
  // Port, address, written byte, byte read back on the other port
  localparam logic [23:0] WR_TAB [12] = '{24'h00FF3F, 24'h110000,
    24'h04FF3F, 24'h150707, 24'h061033, 24'h064040, 24'h173233,
    24'h178033, 24'h08FF00, 24'h19FF00, 24'h0F5500, 24'h1CAA00};
  dcr_host host0 (.mclk(mclk), .req(portReq[0]));
  dcr_host host1 (.mclk(mclk), .req(portReq[1]));
  dcr_control_regs #(.NUM_PORTS(2)) dcr_control_regs_i (
    .mclk(mclk), .sys_rst(sys_rst), .softReset(softReset),
    .portReq(portReq), .portRdata(portRdata), .portRvalid(portRvalid),
    .codecCfg(codecCfg), .osrDivide(), .dacBitFromMod(dacBitFromMod),
    .decimFromInterp(decimFromInterp), .stagesCleared(stagesCleared),
    .codecRunning(codecRunning), .analogPowered(analogPowered),
    .txStageOn(txStageOn), .ampLoopback(ampLoopback),
    .voiceHighpass(voiceHighpass), .inGainDb(inGainDb),
    .mixWeight(mixWeight), .mixActive(mixActive),
    .speakerPowered(speakerPowered), .osrClockExt(osrClockExt),
    .osrDivEff(osrDivEff), .sampleDiv(sampleDiv));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // For a read, d is the expected byte and is queued for the monitor
  task automatic acc(input int p, input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    if (!w) expQ[p].push_back(d);
    if (p == 0) host0.xfer(w, a, d);
    else host1.xfer(w, a, d);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(negedge mclk)
    for (int p = 0; p < 2; p++)
      if (portRvalid[p] === 1'b1) begin
        if (expQ[p].size() == 0) failures++;
        else check(portRdata[p], expQ[p].pop_front());
      end
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // About 150 cycles of traffic; the margin covers a stalled answer
  initial begin
    repeat (2000) @(posedge mclk);
    failures++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hA3093D5A));
    sys_rst = 1'b1;
    softReset = 1'b0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++)
      acc(i % 2, 1'b0, 4'(i), (i < 8) ? RST_MAP[i] : 8'h00);
    foreach (WR_TAB[i]) begin
      acc(WR_TAB[i][20], 1'b1, WR_TAB[i][19:16], WR_TAB[i][15:8]);
      acc(!WR_TAB[i][20], 1'b0, WR_TAB[i][19:16], WR_TAB[i][7:0]);
    end
    check(8'(osrDivEff[0]), 8'h01);
    check(8'(osrDivEff[1]), 8'h07);
    // Codec 0 power word holds 0x3F, codec 1 holds 0x00
    check({dacBitFromMod, decimFromInterp, analogPowered, ampLoopback},
          8'h59);
    repeat (8) begin
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      acc(0, 1'b1, 4'h2, d0);
      acc(1, 1'b1, 4'h3, d1);
      acc(1, 1'b0, 4'h2, d0 & 8'h7F);
      check(8'(mixWeight[0]), RXW[d0[3:2]]);
      check(8'(mixWeight[3]), TXW[d1[1:0]]);
      check(8'(inGainDb[1]), 8'(d1[5:4]) * 8'd12);
      check({6'h00, voiceHighpass}, {6'h00, d1[6], d0[6]});
      check({7'h00, speakerPowered}, {7'h00, |{d0[3:0], d1[3:0]}});
    end
    acc(0, 1'b1, 4'h2, 8'h00);
    acc(0, 1'b1, 4'h3, 8'h00);
    acc(0, 1'b0, 4'h3, 8'h00);
    check({7'h00, speakerPowered}, 8'h00);
    softReset <= 1'b1;
    @(posedge mclk);
    softReset <= 1'b0;
    acc(0, 1'b0, 4'h1, 8'h0C);
    acc(1, 1'b0, 4'h4, 8'h10);
    repeat (4) @(posedge mclk);
    give_verdict();
  end
endmodule
